// ===== hdl/tps_irq.sv
// Interrupt bank: sticky status, mask and one level output.
// Assumes events are single-cycle pulses; set wins over clear.
`timescale 1ns/1ns
module tps_irq (
	input  wire logic       clk_in,     // System clock
	input  wire logic       rst_in,     // Synchronous reset
	input  wire logic       ce_in,      // Clock enable
	input  wire logic [1:0] event_in,   // Event pulses
	input  wire logic [1:0] clear_in,   // Write-one-to-clear bits
	input  wire logic       mask_we_in, // Mask write
	input  wire logic [1:0] mask_in,    // New mask
	output logic      [1:0] stat_out,   // Sticky status
	output logic      [1:0] mask_out,   // Mask
	output logic            irq_out     // Interrupt level
);
	wire [1:0] next_stat = (stat_out & ~clear_in) | event_in; // Event beats clear

	// Status and mask registers
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			stat_out <= 2'h0;
			mask_out <= 2'h0;
			irq_out  <= 1'b0;
		end else if (ce_in) begin
			stat_out <= next_stat;
			if (mask_we_in) begin
				mask_out <= mask_in;
			end
			// Registered so the output stays glitch free
			irq_out <= |(next_stat & (mask_we_in ? mask_in : mask_out));
		end
	end
endmodule

// ===== hdl/tps_pkg.sv
// Constants for the single-output PWM timer: register map, fields, resets.
// Assumes a byte-wide plain register port and one 50 MHz clock.
package tps_pkg;
	// ==========================================================
	// Register offsets (byte port, one byte per register)
	localparam logic [3:0] ADDR_CTRL     = 4'h0; // Control
	localparam logic [3:0] ADDR_CNT_HI   = 4'h1; // Count high byte
	localparam logic [3:0] ADDR_CNT_LO   = 4'h2; // Count low byte
	localparam logic [3:0] ADDR_PWM_HI   = 4'h3; // Match high byte
	localparam logic [3:0] ADDR_PWM_LO   = 4'h4; // Match low byte
	localparam logic [3:0] ADDR_RLD_HI   = 4'h5; // Reload high byte
	localparam logic [3:0] ADDR_RLD_LO   = 4'h6; // Reload low byte
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h7; // Sticky status, write one to clear
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h8; // Interrupt mask
	// ==========================================================
	// Control register fields
	localparam int CTRL_EN_BIT   = 7; // Timer enable
	localparam int CTRL_POL_BIT  = 6; // Output polarity select
	localparam int CTRL_PRE_LSB  = 3; // Prescale exponent, 3 bits
	localparam int CTRL_MODE_LSB = 0; // Mode, 3 bits
	localparam logic [2:0] MODE_PWM_SINGLE = 3'h3; // Single-output PWM code
	// ==========================================================
	// Status fields
	localparam int STAT_RELOAD_BIT = 0; // Reload reached
	localparam int STAT_MATCH_BIT  = 1; // Match reached
	// ==========================================================
	// Reset values
	localparam logic [7:0]  CTRL_RESET   = 8'h00;
	localparam logic [15:0] COUNT_RESTART = 16'h0001; // Count after each reload
	localparam logic [15:0] WORD_RESET   = 16'h0000;
	localparam logic [7:0]  BYTE_RESET   = 8'h00;
endpackage

// ===== hdl/tps_prescaler.sv
// Prescaler: emits a one-cycle tick every 2^exp enabled clocks.
// Assumes synchronous active-high reset and a shared clock enable.
`timescale 1ns/1ns
module tps_prescaler (
	input  wire logic       clk_in,   // System clock
	input  wire logic       rst_in,   // Synchronous reset
	input  wire logic       ce_in,    // Clock enable
	input  wire logic       run_in,   // Timer running
	input  wire logic [2:0] exp_in,   // Divide by 2^exp
	output logic            tick_out  // Count advance pulse
);
	// ==========================================================
	// Divider
	logic [7:0] div;                  // Free count while running
	wire  [7:0] limit = 8'(({1'b0, 8'h01} << exp_in) - 9'h001); // Terminal value
	wire        at_limit = (div == limit);

	// Tick combinational so the counter moves on the same edge
	assign tick_out = run_in && ce_in && at_limit;

	// Count restarts when stopped so each period starts aligned
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			div <= 8'h00;
		end else if (ce_in) begin
			if (!run_in || at_limit) begin
				div <= 8'h00;
			end else begin
				div <= div + 8'h01;
			end
		end
	end
endmodule

// ===== hdl/tps_timer.sv
// Single-output PWM timer with byte register port and interrupt.
// Assumes a bus master with one-cycle strobes and no wait states.
`timescale 1ns/1ns

// What this block does
// - Count up toward sixteen-bit match value
// - Invert output when count equals match
// - At reload: interrupt, count to 0001H
// - Polarity one: start high, low, high
// - Polarity zero: start low, high, low
// - Written start count only affects first period
// - Period equals reload times prescale over clock
module tps_timer (
	input  wire logic       clk_in,      // 50 MHz system clock
	input  wire logic       rst_in,      // Synchronous reset
	input  wire logic       ce_in,       // Clock enable, freezes all state
	input  wire logic [3:0] addr_in,     // Register address
	input  wire logic [7:0] wdata_in,    // Write data
	input  wire logic       wr_in,       // Write strobe
	input  wire logic       rd_in,       // Read strobe
	output logic      [7:0] rdata_out,   // Read data, cycle after strobe
	output logic            pwm_out,     // Timer output to the pin mux
	output logic            irq_out      // Interrupt level
);
	// ==========================================================
	// Registers
	logic [7:0]  ctrl;        // Control byte
	logic [15:0] count;       // Live count
	logic [15:0] match_val;   // Toggle point
	logic [15:0] reload_val;  // Period end
	logic [7:0]  cnt_lo_hold; // Low count byte, reloaded from count every cycle except during a low read
	logic        level;       // Output level before the output flop

	// ==========================================================
	// Decode
	wire wr_ctrl = wr_in && (addr_in == tps_pkg::ADDR_CTRL);
	wire wr_chi  = wr_in && (addr_in == tps_pkg::ADDR_CNT_HI);
	wire wr_clo  = wr_in && (addr_in == tps_pkg::ADDR_CNT_LO);
	wire wr_phi  = wr_in && (addr_in == tps_pkg::ADDR_PWM_HI);
	wire wr_plo  = wr_in && (addr_in == tps_pkg::ADDR_PWM_LO);
	wire wr_rhi  = wr_in && (addr_in == tps_pkg::ADDR_RLD_HI);
	wire wr_rlo  = wr_in && (addr_in == tps_pkg::ADDR_RLD_LO);
	wire wr_stat = wr_in && (addr_in == tps_pkg::ADDR_IRQ_STAT);
	wire wr_mask = wr_in && (addr_in == tps_pkg::ADDR_IRQ_MASK);

	wire       enabled = ctrl[tps_pkg::CTRL_EN_BIT];
	wire       pol     = ctrl[tps_pkg::CTRL_POL_BIT];
	wire [2:0] mode    = ctrl[tps_pkg::CTRL_MODE_LSB +: 3];
	wire [2:0] pre_exp = ctrl[tps_pkg::CTRL_PRE_LSB +: 3];
	wire       running = enabled && (mode == tps_pkg::MODE_PWM_SINGLE);

	// Rising edge of enable restores the idle output level
	wire start = wr_ctrl && wdata_in[tps_pkg::CTRL_EN_BIT] && !enabled;

	// ==========================================================
	// Prescaler and interrupt bank
	logic       tick;        // One count step
	logic [1:0] stat;        // Sticky status
	logic [1:0] mask;        // Interrupt mask

	tps_prescaler u_pre (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.ce_in    (ce_in),
		.run_in   (running),
		.exp_in   (pre_exp),
		.tick_out (tick)
	);

	wire hit_reload = tick && (count == reload_val);
	wire hit_match  = tick && (count == match_val) && !hit_reload;

	tps_irq u_irq (
		.clk_in     (clk_in),
		.rst_in     (rst_in),
		.ce_in      (ce_in),
		.event_in   ({hit_match, hit_reload}),
		.clear_in   (wr_stat ? wdata_in[1:0] : 2'h0),
		.mask_we_in (wr_mask),
		.mask_in    (wdata_in[1:0]),
		.stat_out   (stat),
		.mask_out   (mask),
		.irq_out    (irq_out)
	);

	// ==========================================================
	// Count register
	// Writes land even while running; software owns that
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			count <= tps_pkg::WORD_RESET;
		end else if (ce_in) begin
			if (wr_chi) begin
				count[15:8] <= wdata_in;
			end else if (wr_clo) begin
				count[7:0] <= wdata_in;
			end else if (hit_reload) begin
				count <= tps_pkg::COUNT_RESTART;
			end else if (tick) begin
				count <= count + 16'h0001;
			end
		end
	end

	// ==========================================================
	// Match, reload and control registers
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ctrl       <= tps_pkg::CTRL_RESET;
			match_val  <= tps_pkg::WORD_RESET;
			reload_val <= tps_pkg::WORD_RESET;
		end else if (ce_in) begin
			if (wr_ctrl) begin
				ctrl <= wdata_in;
			end
			if (wr_phi) begin
				match_val[15:8] <= wdata_in;
			end
			if (wr_plo) begin
				match_val[7:0] <= wdata_in;
			end
			if (wr_rhi) begin
				reload_val[15:8] <= wdata_in;
			end
			if (wr_rlo) begin
				reload_val[7:0] <= wdata_in;
			end
		end
	end

	// ==========================================================
	// Output level
	// Idle level loads polarity on the enable write; held while disabled
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			level <= 1'b0;
		end else if (ce_in) begin
			if (start) begin
				level <= wdata_in[tps_pkg::CTRL_POL_BIT];
			end else if (hit_reload) begin
				level <= pol;
			end else if (hit_match) begin
				level <= ~level;
			end
		end
	end

	// Output flop keeps the pin straight from a register
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pwm_out <= 1'b0;
		end else if (ce_in) begin
			pwm_out <= level;
		end
	end

	// ==========================================================
	// Read path
	wire [7:0] rd_mux =
		(addr_in == tps_pkg::ADDR_CTRL)     ? ctrl :
		(addr_in == tps_pkg::ADDR_CNT_HI)   ? count[15:8] :
		(addr_in == tps_pkg::ADDR_CNT_LO)   ? cnt_lo_hold :
		(addr_in == tps_pkg::ADDR_PWM_HI)   ? match_val[15:8] :
		(addr_in == tps_pkg::ADDR_PWM_LO)   ? match_val[7:0] :
		(addr_in == tps_pkg::ADDR_RLD_HI)   ? reload_val[15:8] :
		(addr_in == tps_pkg::ADDR_RLD_LO)   ? reload_val[7:0] :
		(addr_in == tps_pkg::ADDR_IRQ_STAT) ? {6'h00, stat} :
		(addr_in == tps_pkg::ADDR_IRQ_MASK) ? {6'h00, mask} :
		8'h00; // Unmapped reads zero

	// Low byte tracks count except during a low read, so only back-to-back high-low reads are coherent
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cnt_lo_hold <= tps_pkg::BYTE_RESET;
			rdata_out   <= tps_pkg::BYTE_RESET;
		end else if (ce_in) begin
			if (rd_in && addr_in == tps_pkg::ADDR_CNT_HI) begin
				cnt_lo_hold <= count[7:0];
			end else if (!(rd_in && addr_in == tps_pkg::ADDR_CNT_LO)) begin
				cnt_lo_hold <= count[7:0];
			end
			rdata_out <= rd_in ? rd_mux : 8'h00;
		end
	end
endmodule

// ===== testbench/tb.sv
// Bench: drives the PWM timer over its register port.
// Assumes the load model only watches the output pin.
`timescale 1ns/1ns
module tb;
	logic        clk_in = 1'b0, rst_in = 1'b1, wr_in = 1'b0, rd_in = 1'b0;
	logic        ce_in = 1'b1; // Clock enable, dropped once per case while the timer is stopped
	logic [3:0]  addr_in = 4'h0;
	logic [7:0]  wdata_in = 8'h00, rdata_out;
	logic        pwm_out, irq_out;
	logic [15:0] edges;
	int          cyc = 0, n_fail = 0, n_compared = 0;
	always #10 clk_in = ~clk_in;
	always @(posedge clk_in) cyc <= cyc + 1;
	// Clock enable low only while stopped, so the checker's cycle counts stay true
	tps_timer u_tps_timer (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .addr_in(addr_in), .wdata_in(wdata_in),
		.wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pwm_out(pwm_out), .irq_out(irq_out));
	tps_load u_tps_load (.clk_in(clk_in), .pin_in(pwm_out), .edges_out(edges));
	// ==========
	// Bus and compare tasks
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		n_compared++;
		if (got !== want) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= v;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		@(negedge clk_in);
		v = rdata_out;
	endtask
	// Poll on falling edges so the output has settled
	task automatic wt(input logic lv, output int t);
		int k;
		k = 0;
		@(negedge clk_in);
		while (pwm_out !== lv && k < 500) begin
			@(negedge clk_in);
			k++;
		end
		t = cyc;
		chk(k < 500, 1'b1);
	endtask
	// ==========
	// One PWM setup, first phase and two timed periods, disable, interrupt handling
	task automatic pwm_case(input logic pol, input logic [2:0] ex, input logic [15:0] st, mt, rl);
		int te, t0, t1, t2, tk;
		logic [7:0] v, h, g, cfg;
		logic [15:0] c0;
		logic lv;
		cfg = {1'b0, pol, ex, tps_pkg::MODE_PWM_SINGLE};
		tk = (st <= mt) ? mt - st + 1 : rl - st + 1 + mt;
		wr(tps_pkg::ADDR_CTRL, cfg);
		wr(tps_pkg::ADDR_CNT_HI, st[15:8]);
		wr(tps_pkg::ADDR_CNT_LO, st[7:0]);
		wr(tps_pkg::ADDR_PWM_HI, mt[15:8]);
		wr(tps_pkg::ADDR_PWM_LO, mt[7:0]);
		wr(tps_pkg::ADDR_RLD_HI, rl[15:8]);
		wr(tps_pkg::ADDR_RLD_LO, rl[7:0]);
		wr(tps_pkg::ADDR_IRQ_STAT, 8'h03);
		wr(tps_pkg::ADDR_IRQ_MASK, 8'h01);
		wr(tps_pkg::ADDR_CTRL, cfg | 8'h80);
		te = cyc;
		repeat (3) @(negedge clk_in);
		chk(pwm_out, pol);
		wt(!pol, t0);
		chk(t0 - te >= ((tk - 1) << ex) && t0 - te <= (tk << ex) + 4, 1'b1);
		wt(pol, t1);
		chk(t1 - t0, (rl - mt) << ex);
		wt(!pol, t2);
		chk(t2 - t0, rl << ex);
		wt(pol, t1);
		wt(!pol, t0);
		chk(t0 - t2, rl << ex);
		chk(irq_out, 1'b1);
		rd(tps_pkg::ADDR_IRQ_STAT, v);
		chk(v, 8'h03);
		wr(tps_pkg::ADDR_CTRL, cfg);
		rd(tps_pkg::ADDR_CNT_HI, h);
		rd(tps_pkg::ADDR_CNT_LO, g);
		c0 = {h, g};
		lv = pwm_out;
		chk(c0 >= 16'h0001 && c0 <= rl, 1'b1);
		repeat (40) @(negedge clk_in);
		rd(tps_pkg::ADDR_CNT_HI, h);
		rd(tps_pkg::ADDR_CNT_LO, g);
		chk({h, g}, c0);
		chk(pwm_out, lv);
		wr(tps_pkg::ADDR_IRQ_MASK, 8'h00);
		repeat (2) @(negedge clk_in);
		chk(irq_out, 1'b0);
		wr(tps_pkg::ADDR_IRQ_STAT, 8'h03);
		rd(tps_pkg::ADDR_IRQ_STAT, v);
		chk(v, 8'h00);
		rd(tps_pkg::ADDR_RLD_HI, v);
		chk(v, rl[15:8]);
		rd(4'hf, v);
		chk(v, 8'h00);
		ce_in <= 1'b0;
		wr(tps_pkg::ADDR_PWM_LO, 8'h55);
		ce_in <= 1'b1;
		rd(tps_pkg::ADDR_PWM_LO, v);
		chk(v, mt[7:0]);
		chk(edges != 16'h0000, 1'b1);
		$display("test done pol=%0d exp=%0d", pol, ex);
	endtask
	task automatic end_of_test;
		$display("compared=%0d failed=%0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk_in);
		rst_in <= 1'b0;
		pwm_case(1'b0, 3'h0, 16'h0001, 16'h0003, 16'h0006);
		pwm_case(1'b1, 3'h2, 16'h000a, 16'h0003, 16'h000c);
		end_of_test;
	end
	// Watchdog: far beyond the few hundred cycles the tests need
	initial begin
		#400000;
		n_fail++;
		end_of_test;
	end
endmodule

// ===== testbench/tps_load.sv
// Load model: counts level changes seen on the timer pin.
// Assumes a push-pull pin that is never released.
`timescale 1ns/1ns
module tps_load (
	input  wire logic        clk_in,   // System clock
	input  wire logic        pin_in,   // Pin level
	output wire logic [15:0] edges_out // Changes seen
);
	logic        last = 1'b0;
	logic [15:0] cnt  = 16'h0000;
	assign edges_out = cnt;
	// Only a clean change counts, so a floating pin adds nothing
	always @(posedge clk_in) begin
		if (pin_in === ~last)
			cnt <= cnt + 16'h0001;
		last <= pin_in;
	end
endmodule

// ===== testbench/tps_timer_props.sv
// Checker for the PWM timer, port side only.
// Assumes registers change only through the write strobe.
`timescale 1ns/1ns
module tps_timer_props (
	input wire logic       clk_in,
	input wire logic       rst_in,
	input wire logic [3:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic       wr_in,
	input wire logic       pwm_out,
	input wire logic       irq_out
);
	// ==========
	// Shadows and edge timing
	logic [7:0] c, mh, ml, rh, rl;
	logic [1:0] m, a, d;
	logic       p;
	int         n, l;
	wire        e  = pwm_out != p;
	wire        ba = e && pwm_out == c[6] && c[7]; // Back to rest level
	wire        aw = e && pwm_out != c[6] && c[7]; // Away from rest level
	wire [31:0] tr = {16'h0, rh, rl} << c[5:3];
	wire [31:0] tm = {16'h0, mh, ml} << c[5:3];
	// Edge count clears on any write, so setup never trips a length check
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			{c, mh, ml, rh, rl, m, a, d, p} <= '0;
			{n, l} <= '0;
		end else begin
			p <= pwm_out;
			n <= e ? 1 : n + 1;
			l <= e ? n : l;
			a <= wr_in ? 2'h0 : (e && a != 2'h3) ? a + 2'h1 : a;
			d <= c[7] ? 2'h0 : (d == 2'h3) ? d : d + 2'h1;
			if (wr_in)
				case (addr_in)
					tps_pkg::ADDR_CTRL: c <= wdata_in;
					tps_pkg::ADDR_PWM_HI: mh <= wdata_in;
					tps_pkg::ADDR_PWM_LO: ml <= wdata_in;
					tps_pkg::ADDR_RLD_HI: rh <= wdata_in;
					tps_pkg::ADDR_RLD_LO: rl <= wdata_in;
					tps_pkg::ADDR_IRQ_MASK: m <= wdata_in[1:0];
					default: ;
				endcase
		end
	end
	// ==========
	// Properties
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	sequence s_en(logic pl);
		wr_in && addr_in == tps_pkg::ADDR_CTRL && wdata_in[7] && wdata_in[6] == pl && !c[7];
	endsequence
	property p_start_hi; s_en(1'b1) |-> ##[1:2] pwm_out; endproperty
	a_start_hi: assert property (p_start_hi) else $error("output not high after enable");
	property p_start_lo; s_en(1'b0) |-> ##[1:2] !pwm_out; endproperty
	a_start_lo: assert property (p_start_lo) else $error("output not low after enable");
	property p_width; ba && a >= 2'h2 |-> n == tr - tm; endproperty
	a_width: assert property (p_width) else $error("toggled phase length wrong");
	property p_restart; aw && a == 2'h3 |-> n == tm; endproperty
	a_restart: assert property (p_restart) else $error("period did not restart from one");
	property p_period; aw && a == 2'h3 |-> n + l == tr; endproperty
	a_period: assert property (p_period) else $error("period length wrong");
	property p_irq; ba && a != 2'h0 && m[0] |-> ##[0:2] irq_out; endproperty
	a_irq: assert property (p_irq) else $error("no interrupt at reload");
	property p_masked; (m == 2'h0) [*3] |-> !irq_out; endproperty
	a_masked: assert property (p_masked) else $error("interrupt while masked");
	property p_hold; d == 2'h3 |-> $stable(pwm_out); endproperty
	a_hold: assert property (p_hold) else $error("output moved while disabled");
endmodule
bind tps_timer tps_timer_props u_tps_timer_props (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in),
	.wdata_in(wdata_in), .wr_in(wr_in), .pwm_out(pwm_out), .irq_out(irq_out));
